// File: gamma_eeprom_write_recall_ctrl.sv
`timescale 1ns/1ps
module gamma_eeprom_write_recall_ctrl #(
	parameter int unsigned RECALL_CYCLES = gamma_nv_pkg::RECALL_CYCLES_DEF,
	parameter int unsigned PROG_CH_CYCLES = gamma_nv_pkg::PROG_CH_CYCLES_DEF
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_digital_supply_ok,
	input wire logic i_analog_uv,
	input wire logic i_amp_uv,
	input wire logic i_over_temp,
	input wire logic i_write_guard_n,
	input wire logic i_bus_start,
	input wire logic i_bus_stop,
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_byte,
	output logic o_ack,
	output logic o_busy,
	output logic o_recall_busy,
	output logic o_prog_busy,
	output logic o_gamma_en,
	output logic o_com_en,
	output logic [gamma_nv_pkg::NUM_CH*gamma_nv_pkg::CODE_W-1:0] o_dac_codes
);
	import gamma_nv_pkg::*;

	ctl_state_t ctl_reg;
	ctl_state_t ctl_next;
	phase_t phase_reg;
	phase_t phase_next;
	logic [7:0] ptr_reg;
	logic [7:0] ptr_next;
	logic [7:0] upper_reg;
	logic [7:0] upper_next;
	logic upper_ok_reg;
	logic upper_ok_next;
	logic [CODE_W-1:0] dac_reg [NUM_CH];
	logic [CODE_W-1:0] dac_next [NUM_CH];
	logic [CODE_W-1:0] ee_reg [NUM_CH];
	logic [CODE_W-1:0] ee_next [NUM_CH];
	logic [CODE_W-1:0] pval_reg [NUM_CH];
	logic [CODE_W-1:0] pval_next [NUM_CH];
	logic [NUM_CH-1:0] pend_reg;
	logic [NUM_CH-1:0] pend_next;
	logic [3:0] scan_reg;
	logic [3:0] scan_next;
	logic ack_reg;
	logic ack_next;
	logic in_txn_reg;
	logic in_txn_next;
	logic supply_prev_reg;
	logic recalled_reg;
	logic recalled_next;
	logic gamma_en_reg;
	logic gamma_en_next;
	logic com_en_reg;
	logic com_en_next;
	logic timer_load;
	logic [TIMER_W-1:0] timer_cycles;
	logic timer_busy;
	logic timer_done;
	logic [7:0] ch_off;
	logic ch_ok;
	logic [3:0] ch_idx;

	if (RECALL_CYCLES < 1 || PROG_CH_CYCLES < 1 || PROG_CH_CYCLES > PROG_ONE_MAX_CYCLES)
	begin : g_bad_timing
		$error("timing parameters out of range");
	end

	gamma_nv_timer #(
		.W(TIMER_W)
	) u_timer (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_load(timer_load),
		.i_cycles(timer_cycles),
		.o_busy(timer_busy),
		.o_done(timer_done)
	);

	// pointer to channel decode
	assign ch_off = ptr_reg - PTR_CH_BASE;
	assign ch_ok = (ptr_reg >= PTR_CH_BASE) && (ch_off < 8'(NUM_CH));
	assign ch_idx = ch_off[3:0];

	// command parsing, recall and programming sequencing
	always_comb
	begin
		ctl_next = ctl_reg;
		phase_next = phase_reg;
		ptr_next = ptr_reg;
		upper_next = upper_reg;
		upper_ok_next = upper_ok_reg;
		dac_next = dac_reg;
		ee_next = ee_reg;
		pval_next = pval_reg;
		pend_next = pend_reg;
		scan_next = scan_reg;
		ack_next = ack_reg;
		in_txn_next = in_txn_reg;
		recalled_next = recalled_reg;
		timer_load = 1'b0;
		timer_cycles = TIMER_W'(PROG_CH_CYCLES);
		if (i_rx_valid)
		begin
			ack_next = 1'b0; // busy default, see [RQ9] see [RQ16]
		end
		if (i_bus_stop)
		begin
			in_txn_next = 1'b0;
		end
		case (ctl_reg)
			CS_RECALL:
			begin
				if (timer_done)
				begin
					for (int i = 0; i < NUM_CH; i++)
					begin
						dac_next[i] = ee_reg[i]; // see [RQ12]
					end
					recalled_next = 1'b1;
					ctl_next = CS_READY;
				end
			end
			CS_READY:
			begin
				if (i_bus_start)
				begin
					phase_next = PH_ADDR;
					in_txn_next = 1'b1;
					if (!in_txn_reg)
					begin
						pend_next = '0; // fresh set per transaction, see [RQ26]
					end
				end
				if (i_rx_valid)
				begin
					ack_next = 1'b1; // ack regardless of guard, see [RQ3]
					case (phase_reg)
						PH_ADDR:
						begin
							phase_next = i_rx_byte[RW_BIT] ? PH_SKIP : PH_PTR;
						end
						PH_PTR:
						begin
							ptr_next = i_rx_byte;
							phase_next = (i_rx_byte == PTR_CONTROL) ? PH_CTRL : PH_UPPER;
						end
						PH_CTRL:
						begin
							phase_next = PH_SKIP;
							if (i_rx_byte == SW_RESET_CODE)
							begin
								ack_next = 1'b0; // see [RQ15]
								ctl_next = CS_RECALL; // see [RQ14]
								timer_load = 1'b1;
								timer_cycles = TIMER_W'(RECALL_CYCLES);
								recalled_next = 1'b0;
								pend_next = '0;
							end
						end
						PH_UPPER:
						begin
							upper_next = i_rx_byte;
							upper_ok_next = i_write_guard_n; // see [RQ25]
							phase_next = PH_LOWER;
						end
						PH_LOWER:
						begin
							phase_next = PH_UPPER;
							ptr_next = ptr_reg + 8'h01;
							// both bytes must pass the guard, see [RQ1] see [RQ2] see [RQ25]
							if (upper_ok_reg && i_write_guard_n && ch_ok)
							begin
								dac_next[ch_idx] = {upper_reg[1:0], i_rx_byte}; // see [RQ23] see [RQ24] see [RQ10]
								if (upper_reg[PROG_FLAG_BIT])
								begin
									pval_next[ch_idx] = {upper_reg[1:0], i_rx_byte}; // see [RQ5]
									pend_next[ch_idx] = 1'b1; // see [RQ26]
								end
							end
						end
						default:
						begin
						end
					endcase
				end
				if (i_bus_stop)
				begin
					phase_next = PH_SKIP;
					if (ctl_next == CS_READY && pend_next != '0)
					begin
						ctl_next = CS_PROG_SCAN; // see [RQ6]
						scan_next = 4'h0;
					end
				end
			end
			CS_PROG_SCAN:
			begin
				if (pend_reg[scan_reg])
				begin
					timer_load = 1'b1; // per-channel program time, see [RQ7]
					ctl_next = CS_PROG_WAIT;
				end
				else if (scan_reg == 4'(NUM_CH - 1))
				begin
					ctl_next = CS_READY;
				end
				else
				begin
					scan_next = scan_reg + 4'h1;
				end
			end
			CS_PROG_WAIT:
			begin
				if (timer_done)
				begin
					ee_next[scan_reg] = pval_reg[scan_reg]; // see [RQ5]
					pend_next[scan_reg] = 1'b0;
					if (scan_reg == 4'(NUM_CH - 1))
					begin
						ctl_next = CS_READY;
					end
					else
					begin
						scan_next = scan_reg + 4'h1;
						ctl_next = CS_PROG_SCAN;
					end
				end
			end
			default:
			begin
				ctl_next = CS_RECALL;
			end
		endcase
		// supply loss cancels everything; its return starts the power-up recall
		if (!i_digital_supply_ok)
		begin
			ctl_next = CS_RECALL;
			recalled_next = 1'b0;
			timer_load = 1'b1;
			timer_cycles = '0;
			pend_next = '0;
			phase_next = PH_SKIP;
		end
		else if (!supply_prev_reg)
		begin
			ctl_next = CS_RECALL; // see [RQ13]
			recalled_next = 1'b0;
			timer_load = 1'b1;
			timer_cycles = TIMER_W'(RECALL_CYCLES);
			pend_next = '0;
			phase_next = PH_SKIP;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			ctl_reg <= CS_RECALL;
			phase_reg <= PH_SKIP;
			ptr_reg <= 8'h00;
			upper_reg <= 8'h00;
			upper_ok_reg <= 1'b0;
			for (int i = 0; i < NUM_CH; i++)
			begin
				dac_reg[i] <= GAMMA_DEFAULT;
				pval_reg[i] <= GAMMA_DEFAULT;
				ee_reg[i] <= (i == COM_CH) ? COM_DEFAULT : GAMMA_DEFAULT; // see [RQ18]
			end
			pend_reg <= '0;
			scan_reg <= 4'h0;
			ack_reg <= 1'b0;
			in_txn_reg <= 1'b0;
			supply_prev_reg <= 1'b0;
			recalled_reg <= 1'b0;
		end
		else
		begin
			ctl_reg <= ctl_next;
			phase_reg <= phase_next;
			ptr_reg <= ptr_next;
			upper_reg <= upper_next;
			upper_ok_reg <= upper_ok_next;
			dac_reg <= dac_next;
			ee_reg <= ee_next;
			pval_reg <= pval_next;
			pend_reg <= pend_next;
			scan_reg <= scan_next;
			ack_reg <= ack_next;
			in_txn_reg <= in_txn_next;
			supply_prev_reg <= i_digital_supply_ok;
			recalled_reg <= recalled_next;
		end
	end

	// output enables: not gated by programming, see [RQ11]
	always_comb
	begin
		gamma_en_next = recalled_next && ctl_next != CS_RECALL // see [RQ16] see [RQ17]
			&& !i_analog_uv && !i_over_temp; // see [RQ19] see [RQ21] see [RQ22]
		com_en_next = gamma_en_next && !i_amp_uv; // see [RQ20] see [RQ17]
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			gamma_en_reg <= 1'b0;
			com_en_reg <= 1'b0;
		end
		else
		begin
			gamma_en_reg <= gamma_en_next;
			com_en_reg <= com_en_next;
		end
	end

	// flattened channel codes, channel 0 in the low bits
	for (genvar g = 0; g < NUM_CH; g++)
	begin : g_codes
		assign o_dac_codes[g*CODE_W +: CODE_W] = dac_reg[g];
	end

	assign o_ack = ack_reg;
	assign o_busy = (ctl_reg != CS_READY);
	assign o_recall_busy = (ctl_reg == CS_RECALL);
	assign o_prog_busy = (ctl_reg == CS_PROG_SCAN) || (ctl_reg == CS_PROG_WAIT);
	assign o_gamma_en = gamma_en_reg;
	assign o_com_en = com_en_reg;
endmodule : gamma_eeprom_write_recall_ctrl

// File: gamma_eeprom_write_recall_ctrl_asserts.sv
`timescale 1ns/1ps
module gamma_eeprom_write_recall_ctrl_asserts #(
	parameter int unsigned RECALL_CYCLES = 20,
	parameter int unsigned PROG_CH_CYCLES = 10
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_digital_supply_ok,
	input wire logic i_analog_uv,
	input wire logic i_amp_uv,
	input wire logic i_over_temp,
	input wire logic i_write_guard_n,
	input wire logic i_bus_stop,
	input wire logic i_rx_valid,
	input wire logic o_ack,
	input wire logic o_busy,
	input wire logic o_recall_busy,
	input wire logic o_prog_busy,
	input wire logic o_gamma_en,
	input wire logic o_com_en,
	input wire logic [gamma_nv_pkg::NUM_CH*gamma_nv_pkg::CODE_W-1:0] o_dac_codes
);
	import gamma_nv_pkg::*;
	localparam int REC_MAX = RECALL_CYCLES + 4;
	localparam int PROG_MAX = NUM_CH * (PROG_CH_CYCLES + 2) + 20;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// recall window and its bounded close
	sequence s_recall_on;
		o_recall_busy && i_digital_supply_ok;
	endsequence
	sequence s_recall_off;
		##[0:REC_MAX] !o_recall_busy;
	endsequence
	a_recall_ends: assert property (s_recall_on |-> s_recall_off)
		else $error("recall overran its time");
	a_busy_nack: assert property (i_rx_valid && o_busy |=> !o_ack)
		else $error("byte taken while busy was acked");
	a_recall_hiz: assert property (o_recall_busy |-> !o_gamma_en && !o_com_en)
		else $error("outputs enabled during recall");
	a_prog_keeps_on: assert property (o_prog_busy && $past(o_gamma_en)
		&& !$past(i_analog_uv) && !$past(i_over_temp) |-> o_gamma_en)
		else $error("outputs dropped during programming");
	a_gamma_cause: assert property (o_gamma_en |-> !o_recall_busy
		&& !$past(i_analog_uv) && !$past(i_over_temp))
		else $error("gamma enable without its conditions");
	a_com_cause: assert property (o_com_en |-> o_gamma_en && !$past(i_amp_uv))
		else $error("common enable without its conditions");
	a_uv_off: assert property (i_analog_uv |=> !o_gamma_en && !o_com_en)
		else $error("outputs on under undervoltage");
	a_guard_drop: assert property (i_rx_valid && !i_write_guard_n && !o_busy
		|=> $stable(o_dac_codes))
		else $error("guarded byte changed a code");
	a_prog_after_stop: assert property ($rose(o_prog_busy) |-> $past(i_bus_stop))
		else $error("programming began without stop");
	a_prog_bound: assert property (o_prog_busy |-> ##[0:PROG_MAX] !o_prog_busy)
		else $error("programming overran its time");
endmodule : gamma_eeprom_write_recall_ctrl_asserts

bind gamma_eeprom_write_recall_ctrl gamma_eeprom_write_recall_ctrl_asserts #(
	.RECALL_CYCLES(RECALL_CYCLES), .PROG_CH_CYCLES(PROG_CH_CYCLES)) chk_u (
	.i_clk(i_clk), .i_rst(i_rst), .i_digital_supply_ok(i_digital_supply_ok),
	.i_analog_uv(i_analog_uv), .i_amp_uv(i_amp_uv), .i_over_temp(i_over_temp),
	.i_write_guard_n(i_write_guard_n), .i_bus_stop(i_bus_stop), .i_rx_valid(i_rx_valid),
	.o_ack(o_ack), .o_busy(o_busy), .o_recall_busy(o_recall_busy), .o_prog_busy(o_prog_busy),
	.o_gamma_en(o_gamma_en), .o_com_en(o_com_en), .o_dac_codes(o_dac_codes));

// File: gamma_eeprom_write_recall_ctrl_tb.sv
`timescale 1ns/1ps
module gamma_eeprom_write_recall_ctrl_tb;
	import gamma_nv_pkg::*;
	logic i_clk = 1'h0;
	logic i_rst = 1'h1;
	logic supply_ok = 1'h1;
	logic analog_uv = 1'h0;
	logic amp_uv = 1'h0;
	logic over_temp = 1'h0;
	logic guard_n = 1'h1;
	logic start, stop, rx_valid, ack, busy, recall_busy, prog_busy, gamma_en, com_en, a;
	logic [7:0] rx_byte;
	logic [NUM_CH*CODE_W-1:0] codes, exp_codes;
	logic [4:0] en_tab [5] = '{5'h10, 5'h03, 5'h0a, 5'h04, 5'h03};
	int fails = 0;
	int tests_run = 0;

	// clock
	always #2 i_clk = ~i_clk;

	gamma_eeprom_write_recall_ctrl #(.RECALL_CYCLES(20), .PROG_CH_CYCLES(10)) dut_u (
		.i_clk(i_clk), .i_rst(i_rst), .i_digital_supply_ok(supply_ok),
		.i_analog_uv(analog_uv), .i_amp_uv(amp_uv), .i_over_temp(over_temp),
		.i_write_guard_n(guard_n), .i_bus_start(start), .i_bus_stop(stop),
		.i_rx_valid(rx_valid), .i_rx_byte(rx_byte), .o_ack(ack), .o_busy(busy),
		.o_recall_busy(recall_busy), .o_prog_busy(prog_busy), .o_gamma_en(gamma_en),
		.o_com_en(com_en), .o_dac_codes(codes));
	gamma_host_model host_u (.i_clk(i_clk), .i_ack(ack), .o_bus_start(start),
		.o_bus_stop(stop), .o_rx_valid(rx_valid), .o_rx_byte(rx_byte));

	// verdict and end of run
	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test
	// compare and count
	task automatic chk(input logic [NUM_CH*CODE_W-1:0] got, input logic [NUM_CH*CODE_W-1:0] want);
		tests_run++;
		if (got !== want)
		begin
			$display("[FAIL] t=%0t got %h want %h", $time, got, want);
			fails++;
		end
	endtask : chk
	// start, write address, pointer
	task automatic open_at(input logic [7:0] ptr);
		host_u.mark(1'h0);
		host_u.put_byte(8'ha0, a);
		chk(a, 1'h1);
		host_u.put_byte(ptr, a);
		chk(a, 1'h1);
	endtask : open_at
	// upper byte then lower byte
	task automatic word(input logic flag, input logic [9:0] v, input logic want);
		host_u.put_byte({1'h0, flag, 4'h0, v[9:8]}, a);
		chk(a, want);
		host_u.put_byte(v[7:0], a);
		chk(a, want);
	endtask : word
	// bounded wait for ready, looking only once outputs have settled
	task automatic wait_idle;
		for (int n = 0; n < 2000 && busy !== 1'h0; n++)
		begin
			@(posedge i_clk);
			#1;
		end
		chk(busy, 1'h0);
	endtask : wait_idle
	// enables settle one cycle after inputs
	task automatic chk_en(input logic g, input logic c);
		repeat (2) @(posedge i_clk);
		#1;
		chk(gamma_en, g);
		chk(com_en, c);
	endtask : chk_en

	// main sequence
	initial
	begin
		repeat (12) @(posedge i_clk);
		#1;
		i_rst = 1'h0;
		exp_codes = '0;
		exp_codes[COM_CH*CODE_W +: CODE_W] = COM_DEFAULT;
		wait_idle();
		chk(codes, exp_codes);
		chk_en(1'h1, 1'h1);
		$display("test power_up done");
		open_at(8'h01);
		word(1'h0, 10'h234, 1'h1);
		exp_codes[9:0] = 10'h234;
		chk(codes, exp_codes);
		word(1'h0, 10'h1ff, 1'h1);
		exp_codes[19:10] = 10'h1ff;
		host_u.mark(1'h1);
		chk_en(1'h1, 1'h1);
		chk(busy, 1'h0);
		chk(codes, exp_codes);
		$display("test plain_write done");
		guard_n = 1'h0;
		open_at(8'h03);
		word(1'h0, 10'h3aa, 1'h1);
		guard_n = 1'h1;
		host_u.put_byte(8'h02, a);
		chk(a, 1'h1);
		guard_n = 1'h0;
		host_u.put_byte(8'h55, a);
		chk(a, 1'h1);
		host_u.mark(1'h1);
		guard_n = 1'h1;
		chk(codes, exp_codes);
		$display("test write_guard done");
		open_at(8'h04);
		word(1'h1, 10'h321, 1'h1);
		exp_codes[39:30] = 10'h321;
		host_u.mark(1'h1);
		chk(prog_busy, 1'h1);
		chk(gamma_en, 1'h1);
		host_u.mark(1'h0);
		host_u.put_byte(8'ha0, a);
		chk(a, 1'h0);
		host_u.mark(1'h1);
		wait_idle();
		chk(codes, exp_codes);
		chk(gamma_en, 1'h1);
		$display("test program done");
		open_at(PTR_CONTROL);
		host_u.put_byte(SW_RESET_CODE, a);
		chk(a, 1'h0);
		chk(recall_busy, 1'h1);
		chk({gamma_en, com_en}, 2'h0);
		host_u.mark(1'h1);
		host_u.mark(1'h0);
		host_u.put_byte(8'ha0, a);
		chk(a, 1'h0);
		host_u.mark(1'h1);
		exp_codes[19:0] = {GAMMA_DEFAULT, GAMMA_DEFAULT};
		wait_idle();
		chk(codes, exp_codes);
		chk_en(1'h1, 1'h1);
		$display("test soft_reset done");
		// read address, other control value and out-of-range pointer: acked, no effect
		host_u.mark(1'h0);
		host_u.put_byte(8'ha1, a);
		chk(a, 1'h1);
		host_u.put_byte(8'h77, a);
		chk(a, 1'h1);
		open_at(PTR_CONTROL);
		host_u.put_byte(8'h05, a);
		chk(a, 1'h1);
		chk(busy, 1'h0);
		open_at(8'h10);
		word(1'h1, 10'h2c3, 1'h1);
		host_u.mark(1'h1);
		chk(prog_busy, 1'h0);
		chk(codes, exp_codes);
		$display("test ignored_bytes done");
		// supply loss holds recall, its return reloads every code from the store
		open_at(8'h01);
		word(1'h0, 10'h155, 1'h1);
		host_u.mark(1'h1);
		exp_codes[9:0] = 10'h155;
		chk(codes, exp_codes);
		supply_ok = 1'h0;
		repeat (3) @(posedge i_clk);
		#1;
		chk(recall_busy, 1'h1);
		chk({gamma_en, com_en}, 2'h0);
		supply_ok = 1'h1;
		exp_codes[9:0] = GAMMA_DEFAULT;
		wait_idle();
		chk(codes, exp_codes);
		chk_en(1'h1, 1'h1);
		$display("test supply_cycle done");
		foreach (en_tab[k])
		begin
			{analog_uv, amp_uv, over_temp} = en_tab[k][4:2];
			chk_en(en_tab[k][1], en_tab[k][0]);
		end
		$display("test enables done");
		stop_test();
	end

	// watchdog
	initial
	begin
		#20000;
		fails++;
		stop_test();
	end
endmodule : gamma_eeprom_write_recall_ctrl_tb

// File: gamma_host_model.sv
`timescale 1ns/1ps
module gamma_host_model (
	input wire logic i_clk,
	input wire logic i_ack,
	output logic o_bus_start,
	output logic o_bus_stop,
	output logic o_rx_valid,
	output logic [7:0] o_rx_byte
);
	// idle levels
	initial
	begin
		o_bus_start = 1'h0;
		o_bus_stop = 1'h0;
		o_rx_valid = 1'h0;
		o_rx_byte = 8'h5a;
	end
	// one-cycle start or stop marker
	task automatic mark(input logic is_stop);
		@(posedge i_clk);
		#1;
		o_bus_start = !is_stop;
		o_bus_stop = is_stop;
		@(posedge i_clk);
		#1;
		o_bus_start = 1'h0;
		o_bus_stop = 1'h0;
	endtask : mark
	// one byte; byte lines flip once released so no stale value lingers
	task automatic put_byte(input logic [7:0] b, output logic ack);
		@(posedge i_clk);
		#1;
		o_rx_valid = 1'h1;
		o_rx_byte = b;
		@(posedge i_clk);
		#1;
		o_rx_valid = 1'h0;
		o_rx_byte = ~b;
		ack = i_ack;
	endtask : put_byte
endmodule : gamma_host_model

// File: gamma_nv_pkg.sv
// Contract
// [RQ1] write-guard low: received data writes to DAC registers and EEPROM are dropped
// [RQ2] write-guard high: data writes to DAC registers and EEPROM are accepted
// [RQ3] well-formed commands are acknowledged whatever the write-guard level
// [RQ4] host keeps write-guard steady while an EEPROM programming cycle runs
// [RQ5] program_flag set: word goes to the DAC register and its EEPROM location
// [RQ6] flagged channels are programmed starting right at the next STOP
// [RQ7] programming lasts at most 35 ms per register, 420 ms for all
// [RQ8] host waits 35 ms or 420 ms after a programming STOP before commands
// [RQ9] bytes arriving while programming runs are answered with NACK
// [RQ10] words without program_flag update only the DAC register, no wait
// [RQ11] outputs stay enabled throughout programming
// [RQ12] a recall overwrites every DAC register with its EEPROM value
// [RQ13] power-up with digital_supply valid recalls EEPROM into DACs, about 6 ms
// [RQ14] control byte 0x06 at pointer 0x00 starts a recall at byte end
// [RQ15] the software-reset control byte is answered with NACK
// [RQ16] during any recall outputs are disabled and every byte is NACKed
// [RQ17] gamma_outputs and common_voltage_output enable together when recall ends
// [RQ18] factory EEPROM: 0x000 on gamma channels, 0x200 on common_voltage_channel
// [RQ19] gamma_outputs enable needs recall done and analog_supply undervoltage cleared
// [RQ20] common_voltage_output enable also needs amplifier_supply undervoltage cleared
// [RQ21] analog_supply undervoltage disables gamma_outputs and common_voltage_output
// [RQ22] over-temperature disables all outputs; they re-enable once it clears
// [RQ23] word: upper byte bits 1:0 = data 9:8, bit 6 = program_flag
// [RQ24] channel value latched when the lower data byte completes
// [RQ25] write-guard sampled once per data byte, decision covers the byte
// [RQ26] flagged channels gathered between START and STOP, exactly those programmed
package gamma_nv_pkg;
	localparam int NUM_CH = 15;
	localparam int CODE_W = 10;
	localparam int COM_CH = 14;
	localparam logic [CODE_W-1:0] GAMMA_DEFAULT = 10'h000;
	localparam logic [CODE_W-1:0] COM_DEFAULT = 10'h200;
	localparam logic [7:0] PTR_CONTROL = 8'h00;
	localparam logic [7:0] SW_RESET_CODE = 8'h06;
	localparam logic [7:0] PTR_CH_BASE = 8'h01;
	localparam int PROG_FLAG_BIT = 6;
	localparam int RW_BIT = 0;
	localparam int CLK_KHZ = 250000;
	localparam int T_RECALL_MS = 6;
	localparam int T_PROG_ONE_MS = 35;
	localparam int T_PROG_ALL_MS = 420;
	localparam int TIMER_W = 32;
	// recall time is typical, taken exactly
	localparam int RECALL_CYCLES_DEF = T_RECALL_MS * CLK_KHZ;
	// per-channel time spreads the all-register bound, rounded down
	localparam int PROG_CH_CYCLES_DEF = (T_PROG_ALL_MS * CLK_KHZ) / NUM_CH;
	localparam int PROG_ONE_MAX_CYCLES = T_PROG_ONE_MS * CLK_KHZ;

	typedef enum logic [1:0] {CS_RECALL, CS_READY, CS_PROG_SCAN, CS_PROG_WAIT} ctl_state_t;
	typedef enum logic [2:0] {PH_SKIP, PH_ADDR, PH_PTR, PH_CTRL, PH_UPPER, PH_LOWER} phase_t;
endpackage : gamma_nv_pkg

// File: gamma_nv_timer.sv
`timescale 1ns/1ps
module gamma_nv_timer #(
	parameter int W = 32
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_load,
	input wire logic [W-1:0] i_cycles,
	output logic o_busy,
	output logic o_done
);
	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;
	logic done_reg;
	logic done_next;

	if (W < 2)
	begin : g_bad_width
		$error("timer width too small");
	end

	// load wins, else count down; done pulses after the last count
	always_comb
	begin
		count_next = count_reg;
		done_next = 1'b0;
		if (i_load)
		begin
			count_next = i_cycles;
		end
		else if (count_reg != '0)
		begin
			count_next = count_reg - W'(1);
			done_next = (count_reg == W'(1));
		end
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			count_reg <= '0;
			done_reg <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			done_reg <= done_next;
		end
	end

	assign o_busy = (count_reg != '0);
	assign o_done = done_reg;
endmodule : gamma_nv_timer
